// [design/dual_preset_pkg.sv]
// package: register map, reset values and timing constants of the dual preset counter
package dual_preset_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned STEP_MS_X100    = 1;          // one duration step is 0.01 s
  localparam int unsigned STEP_CYCLES     = CLK_HZ / 100 * STEP_MS_X100;

  localparam int unsigned CNT_W           = 20;
  localparam int unsigned DUR_W           = 14;
  localparam int unsigned ADDR_W          = 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESET1  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRESET2  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TIME1    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TIME2    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1C;

  localparam int unsigned CTRL_PANEL_EN_BIT = 0;
  localparam int unsigned CTRL_SOFT_RST_BIT = 1;

  localparam logic [CNT_W-1:0] PRESET1_RST  = 20'h00064;
  localparam logic [CNT_W-1:0] PRESET2_RST  = 20'h000C8;
  localparam logic [DUR_W-1:0] DUR_MIN      = 14'h0001;   // 0.01 s
  localparam logic [DUR_W-1:0] DUR_MAX      = 14'h270F;   // 99.99 s
  localparam logic [DUR_W-1:0] DUR_RST      = 14'h000A;   // 0.1 s
  localparam logic [CNT_W-1:0] PRESCALE_RST = 20'h186A0;  // 1.00000
  localparam logic             CTRL_PANEL_RST = 1'b1;

  localparam int unsigned PIN_W = 9;  // count, direction, remote reset, panel reset, prescale switch, four mode bits
  // synchroniser reset levels equal each pin's idle level: count high, up, remote released, panel released
  localparam logic [PIN_W-1:0] PIN_IDLE = 9'h007;
endpackage : dual_preset_pkg

// [design/output_pulse_timer.sv]
// one output duration timer counting in 0.01 s steps
`timescale 1ns/1ps
module output_pulse_timer #(
  parameter int unsigned DUR_W = 14
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_step,
  input  wire logic             i_start,
  input  wire logic             i_clear,
  input  wire logic [DUR_W-1:0] i_dur,
  output logic                  o_active,
  output logic                  o_done
);
  logic [DUR_W-1:0] remain_r;
  logic             active_r;
  logic             done_r;
  wire              last_step = active_r & i_step & (remain_r <= DUR_W'(1));

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_clear) begin
      remain_r <= '0;
      active_r <= 1'b0;
      done_r   <= 1'b0;
    end else if (i_start) begin
      // a restart while running retriggers the full duration
      remain_r <= i_dur;
      active_r <= 1'b1;
      done_r   <= 1'b0;
    end else begin
      done_r <= last_step;
      if (last_step) begin
        active_r <= 1'b0;
        remain_r <= '0;
      end else if (active_r && i_step) begin
        remain_r <= remain_r - DUR_W'(1);
      end
    end
  end

  assign o_active = active_r;
  assign o_done   = done_r;
endmodule : output_pulse_timer

// [design/dual_preset_counter.sv]
// dual preset counter sequencer with sixteen modes and an APB register file
// Function
// - mode 0 counts up, latches out1 at preset 1, out2 at preset 2, continues.
// - mode 0 manual reset zeroes count and turns both outputs off.
// - mode 1 timed outputs at presets, counting continues, manual reset restarts.
// - mode 2 at preset 2 out1 off, out2 latched until manual reset.
// - mode 3 at preset 2 out1 off, timed out2, manual reset to zero.
// - mode 4 at preset 2 out1 off, timed out2, immediate reload to zero.
// - mode 5 both timed, preset 2 reloads zero immediately.
// - mode 6 out1 off, timed out2, reload to zero after out2 ends.
// - mode 7 both timed, reload to zero after out2 ends.
// - mode 8 start at preset 2, latch out1 at preset 1, out2 at zero.
// - mode 9 start at preset 2, timed outputs at preset 1 and zero.
// - mode 10 at zero out1 off, out2 latched until manual reset.
// - mode 11 at zero out1 off, timed out2, manual reset reloads preset 2.
// - mode 12 at zero out1 off, timed out2, immediate reload of preset 2.
// - mode 13 both timed, zero reloads preset 2 immediately.
// - mode 14 out1 off, timed out2, reload preset 2 after out2 ends.
// - mode 15 both timed, reload preset 2 after out2 ends.
// - prescale value changes only while the prescale switch is down.
// - manual reset from panel or remote line overrides everything and restarts.
// - mode taken from four mode-select switch bits.
// - count down while direction low, up while high.
// - each duration 0.01 s to 99.99 s in 0.01 s steps, default 0.1 s.
`timescale 1ns/1ps
module dual_preset_counter
  import dual_preset_pkg::*;
#(
  parameter int unsigned STEP_DIV = dual_preset_pkg::STEP_CYCLES
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_count_pulse_n,
  input  wire logic                              i_count_direction_in,
  input  wire logic                              i_remote_reset_n,
  input  wire logic                              i_panel_reset,
  input  wire logic                              i_prescale_change_enable_switch,
  input  wire logic [3:0]                        i_mode_select_switches,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [dual_preset_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic                                   o_output1,
  output logic                                   o_output2
);
  import dual_preset_pkg::*;

  localparam int unsigned NPIN = PIN_W;

  // pin synchronisers: three flops, a change counts once the second and third agree
  wire  [NPIN-1:0] pin_raw = {i_mode_select_switches, i_prescale_change_enable_switch,
                              i_panel_reset, i_remote_reset_n, i_count_direction_in, i_count_pulse_n};
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_r;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          // idle levels, so neither a count nor a manual reset follows reset
          pin_s1_r[g] <= PIN_IDLE[g];
          pin_s2_r[g] <= PIN_IDLE[g];
          pin_s3_r[g] <= PIN_IDLE[g];
          pin_r[g]    <= PIN_IDLE[g];
        end else begin
          pin_s1_r[g] <= pin_raw[g];
          pin_s2_r[g] <= pin_s1_r[g];
          pin_s3_r[g] <= pin_s2_r[g];
          if (pin_s2_r[g] == pin_s3_r[g]) begin
            pin_r[g] <= pin_s3_r[g];
          end
        end
      end
    end
  endgenerate

  wire       cnt_in_q    = pin_r[0];
  wire       dir_up      = pin_r[1];
  wire       remote_rst  = ~pin_r[2];
  wire       panel_rst   = pin_r[3];
  wire       prescale_sw = pin_r[4];
  wire [3:0] mode        = pin_r[8:5];

  // registers
  logic [CNT_W-1:0] preset1_r;
  logic [CNT_W-1:0] preset2_r;
  logic [DUR_W-1:0] time1_r;
  logic [DUR_W-1:0] time2_r;
  logic [CNT_W-1:0] prescale_r;
  logic             panel_en_r;
  logic             soft_rst_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             latch1_r;
  logic             latch2_r;
  logic             cnt_prev_r;
  logic             reload_wait_r;
  logic [31:0]      step_div_r;
  logic             step_r;
  logic             out1_r;
  logic             out2_r;
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;

  // mode decode: bit 3 selects reset-to-preset (down) operation
  wire [2:0] sub        = mode[2:0];
  wire       reset_to_preset_action        = mode[3];
  wire       timed1     = (sub == 3'd1) | (sub == 3'd5) | (sub == 3'd7);
  wire       timed2     = (sub != 3'd0) & (sub != 3'd2);
  wire       end_kills1 = (sub == 3'd2) | (sub == 3'd3) | (sub == 3'd4) | (sub == 3'd6);
  wire       auto_now   = (sub == 3'd4) | (sub == 3'd5);
  wire       auto_after = (sub == 3'd6) | (sub == 3'd7);
  wire [CNT_W-1:0] start_val = reset_to_preset_action ? preset2_r : '0;
  wire [CNT_W-1:0] end_val   = reset_to_preset_action ? '0 : preset2_r;

  // manual reset overrides every state and restarts the cycle
  wire manual_rst = remote_rst | (panel_rst & panel_en_r) | soft_rst_r;

  // count pulse registers when the input is pulled low
  wire count_step = cnt_prev_r & ~cnt_in_q;
  wire [CNT_W-1:0] stepped = dir_up ? count_r + CNT_W'(1) : count_r - CNT_W'(1);
  wire hit1  = count_step & (stepped == preset1_r);
  wire hit2  = count_step & (stepped == end_val);

  // duration step enable: one pulse every 0.01 s
  wire step_wrap = (step_div_r >= STEP_DIV - 1);

  logic t1_active;
  logic t1_done;
  logic t2_active;
  logic t2_done;

  wire t1_start = hit1 & timed1 & ~manual_rst;
  wire t2_start = hit2 & timed2 & ~manual_rst;
  wire t1_clear = manual_rst | (hit2 & end_kills1);
  // a deferred reload waits for the done pulse of timer two
  wire reload_after = reload_wait_r & t2_done & auto_after;

  output_pulse_timer #(
    .DUR_W (DUR_W)
  ) u_timer1 (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_step    (step_r),
    .i_start   (t1_start),
    .i_clear   (t1_clear),
    .i_dur     (time1_r),
    .o_active  (t1_active),
    .o_done    (t1_done)
  );

  output_pulse_timer #(
    .DUR_W (DUR_W)
  ) u_timer2 (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_step    (step_r),
    .i_start   (t2_start),
    .i_clear   (manual_rst),
    .i_dur     (time2_r),
    .o_active  (t2_active),
    .o_done    (t2_done)
  );

  // counter next value; an immediate reload replaces the step that reached the end point, so the count never holds it
  always_comb begin
    count_nxt = count_r;
    if (manual_rst) begin
      count_nxt = start_val;
    end else if (hit2 && auto_now) begin
      count_nxt = start_val;
    end else if (reload_after) begin
      count_nxt = start_val;
    end else if (count_step) begin
      count_nxt = stepped;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_r       <= '0;
      cnt_prev_r    <= 1'b1;
      latch1_r      <= 1'b0;
      latch2_r      <= 1'b0;
      reload_wait_r <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      cnt_prev_r <= cnt_in_q;
      if (manual_rst) begin
        latch1_r      <= 1'b0;
        latch2_r      <= 1'b0;
        reload_wait_r <= 1'b0;
      end else begin
        if (hit2 && end_kills1) begin
          latch1_r <= 1'b0;
        end else if (hit1 && !timed1) begin
          latch1_r <= 1'b1;
        end
        if (hit2 && !timed2) begin
          latch2_r <= 1'b1;
        end
        if (hit2 && auto_after) begin
          reload_wait_r <= 1'b1;
        end else if (reload_after) begin
          reload_wait_r <= 1'b0;
        end
      end
    end
  end

  // a manual reset drops both loads at once instead of waiting a cycle for the latches
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end else begin
      out1_r <= ~manual_rst & (latch1_r | t1_active);
      out2_r <= ~manual_rst & (latch2_r | t2_active);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      step_div_r <= '0;
      step_r     <= 1'b0;
    end else begin
      step_div_r <= step_wrap ? '0 : step_div_r + 32'd1;
      step_r     <= step_wrap;
    end
  end

  // APB slave: answer in the first access cycle, no wait states
  wire setup   = psel & ~penable;
  wire wr_acc  = psel & penable & pwrite & pready_r & ~pslverr_r;
  wire hit_map = (paddr <= OFS_STATUS) & (paddr[1:0] == 2'b00);
  wire [DUR_W-1:0] wdur = pwdata[DUR_W-1:0];
  wire dur_ok  = (wdur >= DUR_MIN) & (wdur <= DUR_MAX);
  // one write strobe per register keeps the register processes small
  wire wr_ctrl     = wr_acc & (paddr == OFS_CTRL);
  wire wr_preset1  = wr_acc & (paddr == OFS_PRESET1);
  wire wr_preset2  = wr_acc & (paddr == OFS_PRESET2);
  wire wr_time1    = wr_acc & (paddr == OFS_TIME1) & dur_ok;
  wire wr_time2    = wr_acc & (paddr == OFS_TIME2) & dur_ok;
  wire wr_prescale = wr_acc & (paddr == OFS_PRESCALE) & prescale_sw;
  logic [31:0] rd_mux;

  always_comb begin
    case (paddr)
      OFS_CTRL:     rd_mux = {31'h0, panel_en_r};
      OFS_PRESET1:  rd_mux = {12'h0, preset1_r};
      OFS_PRESET2:  rd_mux = {12'h0, preset2_r};
      OFS_TIME1:    rd_mux = {18'h0, time1_r};
      OFS_TIME2:    rd_mux = {18'h0, time2_r};
      OFS_PRESCALE: rd_mux = {12'h0, prescale_r};
      OFS_COUNT:    rd_mux = {12'h0, count_r};
      OFS_STATUS:   rd_mux = {23'h0, prescale_sw, mode, dir_up, out2_r, out1_r, reload_wait_r};
      default:      rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit_map;
      if (setup) begin
        prdata_r <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      panel_en_r <= CTRL_PANEL_RST;
      soft_rst_r <= 1'b0;
    end else begin
      // the soft reset bit is a one-cycle pulse and never reads back
      soft_rst_r <= wr_ctrl & pwdata[CTRL_SOFT_RST_BIT];
      if (wr_ctrl) begin
        panel_en_r <= pwdata[CTRL_PANEL_EN_BIT];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      preset1_r <= PRESET1_RST;
      preset2_r <= PRESET2_RST;
    end else begin
      if (wr_preset1) begin
        preset1_r <= pwdata[CNT_W-1:0];
      end
      if (wr_preset2) begin
        preset2_r <= pwdata[CNT_W-1:0];
      end
    end
  end

  // a duration outside the legal range is dropped silently and the old value stays
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      time1_r <= DUR_RST;
      time2_r <= DUR_RST;
    end else begin
      if (wr_time1) begin
        time1_r <= wdur;
      end
      if (wr_time2) begin
        time2_r <= wdur;
      end
    end
  end

  // the prescale value is only held for software; no scaling is applied to the count
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prescale_r <= PRESCALE_RST;
    end else if (wr_prescale) begin
      prescale_r <= pwdata[CNT_W-1:0];
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign o_output1 = out1_r;
  assign o_output2 = out2_r;
endmodule : dual_preset_counter

// [testbench/dual_preset_counter_assertions.sv]
// checker: port-level properties of the dual preset counter
`timescale 1ns/1ps
module dual_preset_counter_assertions
  import dual_preset_pkg::*;
#(
  parameter int unsigned STEP_DIV = 4
) (
  input wire logic                               i_sys_clk,
  input wire logic                               i_rst,
  input wire logic                               i_remote_reset_n,
  input wire logic                               i_panel_reset,
  input wire logic [3:0]                         i_mode_select_switches,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [dual_preset_pkg::ADDR_W-1:0] paddr,
  input wire logic                               pready,
  input wire logic                               pslverr,
  input wire logic                               o_output1,
  input wire logic                               o_output2
);
  logic [3:0] quiet_r;
  logic [3:0] mode_r;
  logic [2:0] sub;
  logic       setup;
  assign sub   = i_mode_select_switches[2:0];
  assign setup = psel && !penable;
  // pins need several edges to settle, so mode checks wait until nothing could have reset or re-moded the unit
  always_ff @(posedge i_sys_clk) begin
    mode_r <= i_mode_select_switches;
    if (i_rst || !i_remote_reset_n || i_panel_reset || (psel && pwrite) || mode_r != i_mode_select_switches) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  chk_ready_next: assert property (setup |=> pready)
    else $error("no ready in the access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_bad_addr: assert property (setup && (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("bad address not refused");
  chk_good_addr: assert property (setup && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  chk_reset_off: assert property (disable iff (1'b0) i_rst |=> !o_output1 && !o_output2)
    else $error("outputs on during reset");
  chk_remote_hold: assert property (!i_remote_reset_n [*8] |=> !o_output1 && !o_output2)
    else $error("outputs on while remote reset held");
  chk_latch_out2: assert property (quiet_r == 4'hF && sub inside {3'h0, 3'h2} && $past(o_output2) |-> o_output2)
    else $error("latched output two dropped");
  chk_latch_out1: assert property (quiet_r == 4'hF && sub == 3'h0 && $past(o_output1) |-> o_output1)
    else $error("latched output one dropped");
  chk_out1_drop: assert property (quiet_r == 4'hF && sub inside {3'h2, 3'h3, 3'h4, 3'h6} && $rose(o_output2) |-> !o_output1)
    else $error("output one still on at end point");
  cov_refused: cover property (pslverr);
  cov_reload_mode: cover property ($rose(o_output2) && sub == 3'h4);
  cov_out1_drop: cover property ($fell(o_output1) && o_output2);
endmodule : dual_preset_counter_assertions

bind dual_preset_counter dual_preset_counter_assertions #(.STEP_DIV(STEP_DIV)) u_chk (.i_sys_clk, .i_rst,
  .i_remote_reset_n, .i_panel_reset, .i_mode_select_switches, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .o_output1, .o_output2);

// [testbench/pulse_source_model.sv]
// pulse sensor and direction wiring at the count input
`timescale 1ns/1ps
module pulse_source_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_num,
  input  wire logic       i_slow,
  input  wire logic       i_down,
  output logic            o_count_pulse_n,
  output logic            o_count_direction_in,
  output logic            o_busy
);
  int k;
  int w;
  // down-counting modes have the direction line tied to the common return
  assign o_count_direction_in = !i_down;
  initial begin
    o_count_pulse_n = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_sys_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        w = i_slow ? 8 : 3;
        for (k = 0; k < int'(i_num); k++) begin
          o_count_pulse_n <= 1'b0;
          repeat (w) @(posedge i_sys_clk);
          // sensor released: the pull-up brings the line back high
          o_count_pulse_n <= 1'b1;
          repeat (w) @(posedge i_sys_clk);
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule : pulse_source_model

// [testbench/dual_preset_counter_bench.sv]
// self-checking bench: register file over APB and all sixteen counting modes
`timescale 1ns/1ps
module dual_preset_counter_bench;
  import dual_preset_pkg::*;
  localparam int unsigned DIV = 4;
  logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_remote_reset_n = 1'b1, i_panel_reset = 1'b0;
  logic        i_prescale_change_enable_switch = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0]  i_mode_select_switches = 4'h0, npulse = 4'h1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, pv;
  logic        pready, pslverr, o_output1, o_output2, i_count_pulse_n, i_count_direction_in, busy, er;
  logic        go = 1'b0, slow = 1'b0;
  logic [19:0] p1, p2;
  logic [13:0] t2;
  int          bad_count = 0, checks_done = 0;
  logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_PRESET1, OFS_PRESET2, OFS_TIME1, OFS_TIME2, OFS_PRESCALE};
  logic [31:0] dflt [6] = '{32'h1, 32'(PRESET1_RST), 32'(PRESET2_RST), 32'(DUR_RST), 32'(DUR_RST), 32'(PRESCALE_RST)};
  logic [31:0] tin [4] = '{32'h0, 32'h2710, 32'h270F, 32'h1};
  logic [31:0] tout [4] = '{32'hA, 32'hA, 32'h270F, 32'h1};
  always #2.5 i_sys_clk = ~i_sys_clk;
  dual_preset_counter #(.STEP_DIV(DIV)) DUT (.i_sys_clk, .i_rst, .i_count_pulse_n, .i_count_direction_in,
    .i_remote_reset_n, .i_panel_reset, .i_prescale_change_enable_switch, .i_mode_select_switches, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .o_output1, .o_output2);
  pulse_source_model sensor (.i_sys_clk, .i_go(go), .i_num(npulse), .i_slow(slow),
    .i_down(i_mode_select_switches[3]), .o_count_pulse_n(i_count_pulse_n),
    .o_count_direction_in(i_count_direction_in), .o_busy(busy));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_pin(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_pin
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulses(input logic [3:0] n);
    int k;
    k = 0;
    npulse <= n;
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    @(posedge i_sys_clk);
    while (busy === 1'b1 && k < 400) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (k >= 400) bad_count++;
    repeat (10) @(posedge i_sys_clk);
  endtask : pulses
  // count expected now: start value, end point, or reloaded start after an automatic reload
  function automatic logic [31:0] count_exp(input logic [3:0] m, input logic at_end, input logic over);
    logic [19:0] s;
    s = m[3] ? p2 : 20'h0;
    if (!at_end || m[2:0] inside {3'h4, 3'h5} || (over && m[2:0] > 3'h5)) return 32'(s);
    return m[3] ? 32'h0 : 32'(p2);
  endfunction : count_exp
  task automatic count_is(input logic [3:0] m, input logic at_end, input logic over);
    apb(1'b0, OFS_COUNT, 32'h0);
    check_word("count", count_exp(m, at_end, over), rd);
  endtask : count_is
  task automatic run_mode(input logic [3:0] m);
    p1 = 20'($urandom_range(3, 1));
    p2 = p1 + 20'($urandom_range(3, 1));
    t2 = 14'($urandom_range(17, 10));
    slow = 1'($urandom);
    apb(1'b1, OFS_PRESET1, 32'(p1));
    apb(1'b1, OFS_PRESET2, 32'(p2));
    apb(1'b1, OFS_TIME2, 32'(t2));
    i_mode_select_switches <= m;
    repeat (8) @(posedge i_sys_clk);
    // rotate the manual reset source: register, remote line, front panel
    case (int'(m) % 3)
      0: apb(1'b1, OFS_CTRL, 32'h3);
      1: i_remote_reset_n <= 1'b0;
      default: i_panel_reset <= 1'b1;
    endcase
    repeat (10) @(posedge i_sys_clk);
    i_remote_reset_n <= 1'b1;
    i_panel_reset <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    count_is(m, 1'b0, 1'b0);
    check_pin("out1 reset", 1'b0, o_output1);
    check_pin("out2 reset", 1'b0, o_output2);
    pulses(m[3] ? 4'(p2 - p1) : 4'(p1));
    check_pin("out1 preset", 1'b1, o_output1);
    check_pin("out2 early", 1'b0, o_output2);
    pulses(m[3] ? 4'(p1) : 4'(p2 - p1));
    check_pin("out1 end", !(m[2:0] inside {3'h2, 3'h3, 3'h4, 3'h6}), o_output1);
    check_pin("out2 end", 1'b1, o_output2);
    count_is(m, 1'b1, 1'b0);
    repeat ((int'(t2) + 3) * DIV + 12) @(posedge i_sys_clk);
    check_pin("out2 timed", m[2:0] inside {3'h0, 3'h2}, o_output2);
    count_is(m, 1'b1, 1'b1);
    repeat (30 * DIV + 20) @(posedge i_sys_clk);
    check_pin("out1 timed", m[2:0] == 3'h0, o_output1);
    $display("mode %0d done", m);
  endtask : run_mode
  initial begin
    void'($urandom(32'h16DF));
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      check_word("reset value", dflt[i], rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    check_pin("unmapped error", 1'b1, er);
    check_word("unmapped data", 32'h0, rd);
    pv = 32'($urandom_range(32'hF423F, 32'h1));
    apb(1'b1, OFS_PRESCALE, pv);
    apb(1'b0, OFS_PRESCALE, 32'h0);
    check_word("prescale locked", 32'(PRESCALE_RST), rd);
    i_prescale_change_enable_switch <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    apb(1'b1, OFS_PRESCALE, pv);
    apb(1'b0, OFS_PRESCALE, 32'h0);
    check_word("prescale open", pv, rd);
    foreach (tin[i]) begin
      apb(1'b1, OFS_TIME2, tin[i]);
      apb(1'b0, OFS_TIME2, 32'h0);
      check_word("time2", tout[i], rd);
    end
    apb(1'b1, OFS_TIME1, 32'h1E);
    $display("registers done");
    for (int m = 0; m < 16; m++) run_mode(4'(m));
    conclude();
  end
  // at most about 400 cycles per mode are expected; this leaves ample margin
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    bad_count++;
    conclude();
  end
endmodule : dual_preset_counter_bench
